// ==== dv/fsf_far_end.sv ====
// Far-side model: the writer on write_clock and the reader on read_clock, as enable pulses.
// Assumes the bench calls one task at a time; slow inserts idle cycles before each pulse.
`timescale 1ns/1ps
module fsf_far_end import fsf_pkg::*; #(
    parameter int WIDTH = FSF_WIDTH_DEF
) (
    input wire logic ref_clk,
    input wire logic slow,
    output logic wr_clk_en,
    output logic rd_clk_en,
    output logic write_enable_n,
    output logic read_enable_n,
    output logic [WIDTH-1:0] data_in
);
    initial begin
        wr_clk_en = 1'b0;
        rd_clk_en = 1'b0;
        write_enable_n = 1'b1;
        read_enable_n = 1'b1;
        data_in = '0;
    end

    // One write_clock edge; the data lines show the inverse afterwards so nothing stale looks valid.
    task automatic wr_edge(input logic wen_n, input logic [WIDTH-1:0] d);
        if (slow) repeat (2) @(posedge ref_clk);
        @(posedge ref_clk);
        wr_clk_en <= 1'b1;
        write_enable_n <= wen_n;
        data_in <= d;
        @(posedge ref_clk);
        wr_clk_en <= 1'b0;
        write_enable_n <= 1'b1;
        data_in <= ~d;
    endtask

    // One read_clock edge with the given read enable.
    task automatic rd_edge(input logic ren_n);
        if (slow) repeat (2) @(posedge ref_clk);
        @(posedge ref_clk);
        rd_clk_en <= 1'b1;
        read_enable_n <= ren_n;
        @(posedge ref_clk);
        rd_clk_en <= 1'b0;
        read_enable_n <= 1'b1;
    endtask
endmodule // fsf_far_end

// ==== dv/fsf_flags_top_tb_top.sv ====
// Self-checking bench for the FIFO flag block with a small depth.
// Assumes the far-side model and the package are compiled first.
`timescale 1ns/1ps
module fsf_flags_top_tb_top import fsf_pkg::*; ;
    localparam int D = 8;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic master_reset_n = 1'b1;
    logic partial_reset_n = 1'b1;
    logic output_drive_enable_n = 1'b1;
    logic offset_load_n = 1'b1;
    logic serial_enable_n = 1'b1;
    logic mode_select_serial_in = 1'b0;
    logic slow = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [8:0] data_out;
    logic [8:0] data_in;
    logic data_out_oe, full_flag_n, input_ready_n, empty_flag_n, output_ready_n;
    logic almost_full_flag_n, almost_empty_flag_n, wr_clk_en, rd_clk_en, write_enable_n, read_enable_n;
    int n_errors = 0;
    int cmp_count = 0;
    logic [31:0] r;
    logic [14:0] n;
    logic [14:0] m;
    logic b;
    logic [29:0] sh;

    always #10 ref_clk = ~ref_clk;

    fsf_flags_top #(.DEPTH(D), .WIDTH(9)) uut (.ref_clk, .nrst, .master_reset_n, .partial_reset_n,
        .wr_clk_en, .rd_clk_en, .write_enable_n, .data_in, .read_enable_n, .output_drive_enable_n,
        .offset_load_n, .serial_enable_n, .mode_select_serial_in, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .data_out, .data_out_oe, .full_flag_n,
        .input_ready_n, .empty_flag_n, .output_ready_n, .almost_full_flag_n, .almost_empty_flag_n);

    fsf_far_end #(.WIDTH(9)) far (.ref_clk, .slow, .wr_clk_en, .rd_clk_en, .write_enable_n,
        .read_enable_n, .data_in);

    task automatic wrap_up();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    // Avalon-MM master: hold the request until waitrequest is seen low at a rising edge.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        @(posedge ref_clk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= wd;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 20) begin
            n_errors++;
            wrap_up();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic mrst(input logic ft, input logic ld);
        @(posedge ref_clk);
        master_reset_n <= 1'b0;
        mode_select_serial_in <= ft;
        offset_load_n <= ld;
        repeat (2) @(posedge ref_clk);
        master_reset_n <= 1'b1;
        offset_load_n <= 1'b1;
        mode_select_serial_in <= 1'b0;
    endtask

    task automatic ofs_chk(input logic [14:0] ae, input logic [14:0] af);
        bus(1'b0, FSF_REG_AE_OFS, 32'h0, r);
        chk(r, 32'(ae));
        bus(1'b0, FSF_REG_AF_OFS, 32'h0, r);
        chk(r, 32'(af));
    endtask

    // Expected counts: capacity is one word larger in fall-through mode.
    function automatic logic af_exp(input int cnt, input int cap, input int mo);
        return !(cnt >= cap - mo);
    endfunction

    task automatic fill_drain(input logic ft, input int no, input int mo);
        int cap;
        logic [8:0] q[$];
        logic [8:0] d;
        cap = D + 32'(ft);
        slow = 1'($urandom % 2);
        for (int i = 1; i <= cap + 1; i++) begin
            if ($urandom % 4 == 0) far.wr_edge(1'b1, 9'($urandom));
            d = 9'($urandom);
            far.wr_edge(1'b0, d);
            if (i <= cap) q.push_back(d);
            #1;
            chkb(full_flag_n, !(i >= cap));
            chkb(input_ready_n, i >= cap);
            chkb(almost_full_flag_n, af_exp(i, cap, mo));
        end
        repeat (2) far.rd_edge(1'b1);
        #1;
        chkb(ft ? output_ready_n : empty_flag_n, ft);
        far.rd_edge(1'b1);
        #1;
        chkb(ft ? output_ready_n : empty_flag_n, !ft);
        for (int j = cap - 1; j >= 0; j--) begin
            if (ft) chk(32'(data_out), 32'(q[0]));
            far.rd_edge(1'b0);
            far.rd_edge(1'b1);
            #1;
            d = q.pop_front();
            if (!ft) chk(32'(data_out), 32'(d));
            if (!ft) chkb(empty_flag_n, j != 0);
            if (ft) chkb(output_ready_n, j == 0);
            chkb(almost_empty_flag_n, j > no + 32'(ft));
        end
        far.rd_edge(1'b0);
        #1;
        chk(32'(data_out), 32'(d));
        repeat (2) far.wr_edge(1'b1, 9'h0);
        #1;
        chkb(full_flag_n, 1'b0);
        far.wr_edge(1'b1, 9'h0);
        #1;
        chkb(full_flag_n, 1'b1);
        chkb(almost_full_flag_n, 1'b1);
    endtask

    initial begin
        repeat (50000) @(posedge ref_clk);
        n_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(89));
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        mrst(1'b0, 1'b0);
        ofs_chk(15'h007F, 15'h007F);
        bus(1'b0, FSF_REG_STATUS, 32'h0, r);
        chk(r & 32'h0000_0003, 32'h0000_0000);
        chkb(data_out_oe, 1'b0);
        for (int i = 0; i < 4; i++) begin
            b = 1'($urandom);
            output_drive_enable_n <= b;
            repeat (2) @(posedge ref_clk);
            #1;
            chkb(data_out_oe, !b);
        end
        output_drive_enable_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chkb(data_out_oe, 1'b1);
        n = 15'(1 + $urandom % 3);
        m = 15'(1 + $urandom % 3);
        bus(1'b1, FSF_REG_AE_OFS, 32'(n), r);
        ofs_chk(15'h007F, 15'h007F);
        offset_load_n <= 1'b0;
        bus(1'b1, FSF_REG_AE_OFS, 32'(n), r);
        bus(1'b1, FSF_REG_AF_OFS, 32'(m), r);
        bus(1'b1, 4'hC, 32'h0000_0005, r);
        offset_load_n <= 1'b1;
        bus(1'b0, 4'hC, 32'h0, r);
        chk(r, 32'h0000_0000);
        ofs_chk(n, m);
        repeat (3) far.wr_edge(1'b0, 9'h0AA);
        @(posedge ref_clk);
        partial_reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        partial_reset_n <= 1'b1;
        fill_drain(1'b0, n, m);
        ofs_chk(n, m);
        mrst(1'b1, 1'b1);
        ofs_chk(15'h03FF, 15'h03FF);
        bus(1'b0, FSF_REG_STATUS, 32'h0, r);
        chk(r & 32'h0000_0003, 32'h0000_0003);
        offset_load_n <= 1'b0;
        bus(1'b1, FSF_REG_AF_OFS, 32'h0000_0002, r);
        ofs_chk(15'h03FF, 15'h03FF);
        n = 15'(1 + $urandom % 3);
        m = 15'(1 + $urandom % 3);
        sh = {m, n};
        for (int i = 29; i >= 0; i--) begin
            if ($urandom % 4 == 0) begin
                serial_enable_n <= 1'b1;
                mode_select_serial_in <= 1'($urandom);
                far.wr_edge(1'b1, 9'h0);
            end
            serial_enable_n <= 1'b0;
            mode_select_serial_in <= sh[i];
            far.wr_edge(1'b1, 9'h0);
        end
        serial_enable_n <= 1'b1;
        offset_load_n <= 1'b1;
        ofs_chk(n, m);
        fill_drain(1'b1, n, m);
        wrap_up();
    end
endmodule // fsf_flags_top_tb_top

// ==== include/fsf_pkg.sv ====
// Constants, register map and pointer helpers for the FIFO status-flag block.
// Assumes one clock; write and read sides step on one-cycle enable pulses.
package fsf_pkg;

    // ------------------------------------------------------------------
    // Geometry and offsets
    // ------------------------------------------------------------------
    localparam int FSF_DEPTH_DEF = 16384;
    localparam int FSF_WIDTH_DEF = 9;
    localparam logic [15:0] FSF_OFS_PAR_DEF = 16'h007F;
    localparam logic [15:0] FSF_OFS_SER_DEF = 16'h03FF;
    localparam int FSF_SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] FSF_REG_STATUS = 4'h0;
    localparam logic [3:0] FSF_REG_AE_OFS = 4'h4;
    localparam logic [3:0] FSF_REG_AF_OFS = 4'h8;
    localparam int FSF_ST_FALL_BIT = 0;
    localparam int FSF_ST_SERIAL_BIT = 1;
    localparam int FSF_ST_FULL_BIT = 2;
    localparam int FSF_ST_EMPTY_BIT = 3;
    localparam int FSF_ST_AF_BIT = 4;
    localparam int FSF_ST_AE_BIT = 5;

    typedef enum logic [1:0] {
        FSF_BUS_IDLE = 2'b00,
        FSF_BUS_ACK = 2'b01,
        FSF_BUS_DONE = 2'b10
    } fsf_bus_e;

    function automatic logic [31:0] fsf_bin2gray(input logic [31:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [31:0] fsf_gray2bin(input logic [31:0] g);
        logic [31:0] b;
        b = g;
        for (int i = 1; i < 32; i++) begin
            b = b ^ (g >> i);
        end
        return b;
    endfunction

endpackage

// ==== logic/fsf_flags_top.sv ====
// FIFO with offset control and full, empty and programmable flags.
// Assumes wr_clk_en and rd_clk_en mark write_clock and read_clock edges.
// How it works
// - output_drive_enable_n low drives data_out; high releases the bus.
// - offset_load_n low at master reset: offsets 07FH, parallel writes.
// - offset_load_n high at master reset: offsets 3FFH, serial writes.
// - Offsets are written only by the chosen method, gated by offset_load_n.
// - Offsets are read back only over the parallel path.
// - Standard mode: full_flag_n low when full, blocking writes.
// - Standard mode: full after depth writes without reads.
// - Fall-through mode: input_ready_n low while space, high when none.
// - Fall-through mode counts the output word: one more write to fill.
// - Full and input-ready flags update on write edges via two stages.
// - Standard mode: empty_flag_n low when empty, blocking reads.
// - Fall-through: output_ready_n falls with first word valid on data_out.
// - Fall-through: output_ready_n rises only on a true read of last word.
// - Empty and output-ready flags update on read edges, staged.
// - Standard mode: almost-full after depth minus m writes.
// - Fall-through: almost-full after depth plus one minus m writes.
// - almost_full_flag_n changes only on write edges.
// - Standard mode: almost-empty low at n or fewer words.
// - Fall-through: almost-empty low at n plus one or fewer words.
// - almost_empty_flag_n changes only on read edges.
// - mode_select_serial_in at master reset picks fall-through when high.
// - Write enable is ignored while full, in both modes.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
module fsf_flags_top import fsf_pkg::*; #(
    parameter int DEPTH = FSF_DEPTH_DEF,
    parameter int WIDTH = FSF_WIDTH_DEF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic wr_clk_en,
    input wire logic rd_clk_en,
    input wire logic write_enable_n,
    input wire logic [WIDTH-1:0] data_in,
    input wire logic read_enable_n,
    input wire logic output_drive_enable_n,
    input wire logic offset_load_n,
    input wire logic serial_enable_n,
    input wire logic mode_select_serial_in,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [WIDTH-1:0] data_out,
    output logic data_out_oe,
    output logic full_flag_n,
    output logic input_ready_n,
    output logic empty_flag_n,
    output logic output_ready_n,
    output logic almost_full_flag_n,
    output logic almost_empty_flag_n
);
    localparam int AW = $clog2(DEPTH + 1);
    localparam int PW = AW + 1;
    // Offsets are 15 bits so that both defaults fit even at small depths.
    localparam int OW = 15;

    if (DEPTH < 4 || WIDTH < 1 || WIDTH > 32 || DEPTH > 32768) begin : g_bad_param
        $error("fsf_flags_top: unsupported DEPTH or WIDTH");
    end

    // ------------------------------------------------------------------
    // Mode and offset state
    // ------------------------------------------------------------------
    logic fall_q, fall_d, serial_q, serial_d;
    logic [OW-1:0] ae_ofs_q, ae_ofs_d, af_ofs_q, af_ofs_d;
    logic bus_wr_ack;
    logic mres, pres;

    assign mres = !master_reset_n;
    assign pres = mres || !partial_reset_n;

    always_comb begin
        fall_d = fall_q;
        serial_d = serial_q;
        ae_ofs_d = ae_ofs_q;
        af_ofs_d = af_ofs_q;
        if (mres) begin
            fall_d = mode_select_serial_in;
            serial_d = offset_load_n;
            if (offset_load_n) begin
                ae_ofs_d = OW'(FSF_OFS_SER_DEF);
                af_ofs_d = OW'(FSF_OFS_SER_DEF);
            end else begin
                ae_ofs_d = OW'(FSF_OFS_PAR_DEF);
                af_ofs_d = OW'(FSF_OFS_PAR_DEF);
            end
        end else if (serial_q) begin
            if (wr_clk_en && !offset_load_n && !serial_enable_n) begin
                ae_ofs_d = {ae_ofs_q[OW-2:0], mode_select_serial_in};
                af_ofs_d = {af_ofs_q[OW-2:0], ae_ofs_q[OW-1]};
            end
        end else if (bus_wr_ack && !offset_load_n) begin
            if (avs_address == FSF_REG_AE_OFS) begin
                ae_ofs_d = avs_writedata[OW-1:0];
            end
            if (avs_address == FSF_REG_AF_OFS) begin
                af_ofs_d = avs_writedata[OW-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fall_q <= 1'b0;
            serial_q <= 1'b0;
            ae_ofs_q <= OW'(FSF_OFS_PAR_DEF);
            af_ofs_q <= OW'(FSF_OFS_PAR_DEF);
        end else begin
            fall_q <= fall_d;
            serial_q <= serial_d;
            ae_ofs_q <= ae_ofs_d;
            af_ofs_q <= af_ofs_d;
        end
    end

    // ------------------------------------------------------------------
    // Write side
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] mem [2**AW];
    logic [PW-1:0] wptr_q, wptr_d, wgray_q, rgray_w, rcons_w, wcount;
    logic [PW-1:0] cap;
    logic wr_take;
    logic full_n_q, full_n_d, af_n_q, af_n_d, ir_n_q;

    assign cap = fall_q ? PW'(DEPTH + 1) : PW'(DEPTH);
    assign wr_take = wr_clk_en && !write_enable_n && full_n_q && !pres;
    assign rcons_w = PW'(fsf_gray2bin(32'(rgray_w)));

    always_comb begin
        wptr_d = wptr_q;
        full_n_d = full_n_q;
        af_n_d = af_n_q;
        wcount = '0;
        if (pres) begin
            wptr_d = '0;
            full_n_d = 1'b1;
            af_n_d = 1'b1;
        end else if (wr_clk_en) begin
            wptr_d = wptr_q + PW'(wr_take);
            wcount = wptr_d - rcons_w;
            full_n_d = (wcount != cap);
            af_n_d = (32'(wcount) + 32'(af_ofs_q) < 32'(cap));
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wptr_q <= '0;
            wgray_q <= '0;
            full_n_q <= 1'b1;
            ir_n_q <= 1'b0;
            af_n_q <= 1'b1;
        end else begin
            wptr_q <= wptr_d;
            wgray_q <= PW'(fsf_bin2gray(32'(wptr_d)));
            full_n_q <= full_n_d;
            ir_n_q <= !full_n_d;
            af_n_q <= af_n_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_take) begin
            mem[wptr_q[AW-1:0]] <= data_in;
        end
    end

    // ------------------------------------------------------------------
    // Pointer crossings
    // ------------------------------------------------------------------
    logic [PW-1:0] rcons_q, rcons_d, rgray_q, wgray_r, wptr_r;

    fsf_ptr_sync #(.W(PW)) u_rd2wr (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clr(pres),
        .step_en(wr_clk_en),
        .src(rgray_q),
        .dst(rgray_w)
    );

    fsf_ptr_sync #(.W(PW)) u_wr2rd (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clr(pres),
        .step_en(rd_clk_en),
        .src(wgray_q),
        .dst(wgray_r)
    );

    assign wptr_r = PW'(fsf_gray2bin(32'(wgray_r)));

    // ------------------------------------------------------------------
    // Read side: fetch pointer feeds data_out and the empty flag, consume pointer feeds the count flags
    // ------------------------------------------------------------------
    logic [PW-1:0] rptr_q, rptr_d, mcount, tcount;
    logic ov_q, ov_d, fetch, true_rd;
    logic [WIDTH-1:0] dout_q, dout_d;
    logic empty_n_q, empty_n_d, or_n_q, or_n_d, ae_n_q, ae_n_d;
    logic [31:0] ae_lim;

    assign mcount = wptr_r - rptr_q;
    assign true_rd = rd_clk_en && !read_enable_n && ov_q;
    assign ae_lim = 32'(ae_ofs_q) + 32'(fall_q);

    always_comb begin
        rptr_d = rptr_q;
        rcons_d = rcons_q;
        ov_d = ov_q;
        dout_d = dout_q;
        fetch = 1'b0;
        tcount = '0;
        empty_n_d = empty_n_q;
        or_n_d = or_n_q;
        ae_n_d = ae_n_q;
        if (pres) begin
            rptr_d = '0;
            rcons_d = '0;
            ov_d = 1'b0;
            empty_n_d = 1'b0;
            or_n_d = 1'b1;
            ae_n_d = 1'b0;
        end else if (rd_clk_en) begin
            if (fall_q) begin
                fetch = (mcount != '0) && (!ov_q || true_rd);
                ov_d = fetch || (ov_q && !true_rd);
                rcons_d = rcons_q + PW'(true_rd);
            end else begin
                // Gate on the flag itself so that no word leaves while empty is shown.
                fetch = !read_enable_n && empty_n_q;
                rcons_d = rptr_q + PW'(fetch);
            end
            if (fetch) begin
                dout_d = mem[rptr_q[AW-1:0]];
            end
            rptr_d = rptr_q + PW'(fetch);
            empty_n_d = (wptr_r != rptr_d);
            or_n_d = !ov_d;
            tcount = wptr_r - rcons_d;
            ae_n_d = (32'(tcount) > ae_lim);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rptr_q <= '0;
            rcons_q <= '0;
            rgray_q <= '0;
            ov_q <= 1'b0;
            dout_q <= '0;
            empty_n_q <= 1'b0;
            or_n_q <= 1'b1;
            ae_n_q <= 1'b0;
        end else begin
            rptr_q <= rptr_d;
            rcons_q <= rcons_d;
            rgray_q <= PW'(fsf_bin2gray(32'(rcons_d)));
            ov_q <= ov_d;
            dout_q <= dout_d;
            empty_n_q <= empty_n_d;
            or_n_q <= or_n_d;
            ae_n_q <= ae_n_d;
        end
    end

    // ------------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------------
    logic oe_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= !output_drive_enable_n;
        end
    end

    assign data_out = dout_q;
    assign data_out_oe = oe_q;
    assign full_flag_n = full_n_q;
    assign input_ready_n = ir_n_q;
    assign empty_flag_n = empty_n_q;
    assign output_ready_n = or_n_q;
    assign almost_full_flag_n = af_n_q;
    assign almost_empty_flag_n = ae_n_q;

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then a one-cycle answer
    // ------------------------------------------------------------------
    fsf_bus_e bus_q, bus_d;
    logic [31:0] rdata_q, rdata_d, rsel;
    logic wait_q, wait_d;

    assign bus_wr_ack = (bus_q == FSF_BUS_ACK) && avs_write;

    always_comb begin
        rsel = '0;
        case (avs_address)
            FSF_REG_STATUS: begin
                rsel[FSF_ST_FALL_BIT] = fall_q;
                rsel[FSF_ST_SERIAL_BIT] = serial_q;
                rsel[FSF_ST_FULL_BIT] = !full_n_q;
                rsel[FSF_ST_EMPTY_BIT] = !empty_n_q;
                rsel[FSF_ST_AF_BIT] = !af_n_q;
                rsel[FSF_ST_AE_BIT] = !ae_n_q;
            end
            FSF_REG_AE_OFS: rsel = 32'(ae_ofs_q);
            FSF_REG_AF_OFS: rsel = 32'(af_ofs_q);
            default: rsel = '0;
        endcase
    end

    always_comb begin
        bus_d = bus_q;
        wait_d = wait_q;
        rdata_d = rdata_q;
        case (bus_q)
            FSF_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_d = FSF_BUS_ACK;
                    wait_d = 1'b0;
                    rdata_d = avs_read ? rsel : '0;
                end
            end
            FSF_BUS_ACK: begin
                bus_d = FSF_BUS_DONE;
                wait_d = 1'b1;
            end
            FSF_BUS_DONE: bus_d = FSF_BUS_IDLE;
            default: begin
                bus_d = FSF_BUS_IDLE;
                wait_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_q <= FSF_BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            bus_q <= bus_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    AST_OE_FOLLOWS: assert property (!output_drive_enable_n |=> data_out_oe)
        else $error("data_out not driven after enable");
    AST_DEFAULT_PAR: assert property (mres && !offset_load_n ##1 master_reset_n |->
        ae_ofs_q == OW'(FSF_OFS_PAR_DEF) && !serial_q)
        else $error("parallel default offset wrong");
    AST_DEFAULT_SER: assert property (mres && offset_load_n ##1 master_reset_n |->
        af_ofs_q == OW'(FSF_OFS_SER_DEF) && serial_q)
        else $error("serial default offset wrong");
    AST_NO_PAR_IN_SER: assert property (serial_q && master_reset_n |=> $stable(ae_ofs_q) ||
        $past(wr_clk_en && !offset_load_n && !serial_enable_n))
        else $error("offset changed outside serial load");
    AST_NO_WRITE_FULL: assert property (!full_n_q && !pres |=> $stable(wptr_q))
        else $error("write taken while full");
    AST_NEVER_OVER: assert property (wptr_q - rcons_w <= cap)
        else $error("write count passed capacity");
    AST_AF_STABLE: assert property (!wr_clk_en && !pres |=> $stable(almost_full_flag_n))
        else $error("almost-full moved without write edge");
    AST_AE_STABLE: assert property (!rd_clk_en && !pres |=> $stable(almost_empty_flag_n))
        else $error("almost-empty moved without read edge");
    AST_OR_HOLD: assert property (fall_q && !output_ready_n && !(rd_clk_en && !read_enable_n)
        && !pres |=> !output_ready_n && $stable(data_out))
        else $error("output word lost without a read");
    AST_EMPTY_BLOCK: assert property (!fall_q && !empty_flag_n && !pres ##1 !empty_flag_n
        |-> $stable(rptr_q))
        else $error("read taken while empty");

    COV_FULL: cover property (!full_flag_n);
    COV_FALL_FIRST: cover property (fall_q && output_ready_n ##1 !output_ready_n);
    COV_OFS_WRITE: cover property (bus_wr_ack && !offset_load_n && !serial_q);
endmodule // fsf_flags_top

// ==== logic/fsf_ptr_sync.sv ====
// Two-stage pointer synchroniser stepped by the destination side's enable.
// Assumes the source value is gray coded so one bit changes per step.
`timescale 1ns/1ps
module fsf_ptr_sync import fsf_pkg::*; #(
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic step_en,
    input wire logic [W-1:0] src,
    output logic [W-1:0] dst
);
    logic [W-1:0] s1_q, s1_d, s2_q, s2_d;

    always_comb begin
        s1_d = s1_q;
        s2_d = s2_q;
        if (clr) begin
            s1_d = '0;
            s2_d = '0;
        end else if (step_en) begin
            s1_d = src;
            s2_d = s1_q;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign dst = s2_q;
endmodule // fsf_ptr_sync
